// ===== adcdm_top.sv
// Functional notes
// - All timing runs on the rising sample clock.
// - Port data changes only at data-ready rise, except in full rate mode, where primary data loads every cycle.
// - Samples split between primary and auxiliary ports in half and quarter rate modes.
// - Reset input is captured on the sample clock.
// - Undriven reset pair reads as inactive.
// - Latched reset is pipelined to align with data.
// - Counter makes half or quarter rate clock; full rate toggles the data-ready flop.
// - Enable and select decode the three modes.
// - Counter power-up phase is not the reset phase.
// - Reset forces the counter to one phase in half rate mode; in quarter rate mode only from counts 0 and 1.
// - Data-ready keeps toggling while reset output asserted.
// - Auxiliary and primary latencies are 8.5 and 7.5.
// - Older sample of each pair goes to auxiliary.
// - Reset output latency is 6.5 cycles.
// - Phase is checked against the reset phase when reset is first latched.
// - Matching phase leaves clock and data undisturbed.
// - Opposite phase drops one cycle, order reverses.
// - Single converter needs no reset for ordering.
// - Dropping a cycle suppresses the reset output pulse.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module adcdm_top (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire logic [adcdm_pkg::SAMPLE_W-1:0]  sample_in,
  input  wire logic                            sync_reset_in_true,
  input  wire logic                            sync_reset_in_comp,
  output logic      [adcdm_pkg::SAMPLE_W-1:0]  primary_data,
  output logic      [adcdm_pkg::SAMPLE_W-1:0]  aux_data,
  output logic                                 data_ready_clock_true,
  output logic                                 data_ready_clock_comp,
  output logic                                 aligned_reset_out_true,
  output logic                                 aligned_reset_out_comp
);

  // Address match, used for both read and write decoding.
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
    return a == off;
  endfunction

  // Counter bits that must match the reset phase in each mode.
  function automatic logic [1:0] phase_mask(input adcdm_pkg::adcdm_mode_e m);
    logic [1:0] r;
    r = 2'h0;
    if (m == adcdm_pkg::ADCDM_HALF) begin
      r = 2'h1;
    end else if (m == adcdm_pkg::ADCDM_QUARTER) begin
      r = 2'h3;
    end
    return r;
  endfunction

  // Registers.
  logic [1:0]                      ctrl;
  logic [1:0]                      rst_pin_meta;
  logic [1:0]                      rst_pin_sync;
  logic [1:0]                      cnt;
  logic                            aligned;
  logic                            swallow_seen;
  logic [7:0]                      swallow_count;
  logic                            ap_valid;
  logic                            ap_write;
  logic                            ap_ctrl;

  // Combinational nets.
  adcdm_pkg::adcdm_mode_e          mode;
  logic                            reset_latched;
  logic                            rst_first;
  logic                            phase_match;
  logic                            mismatch_now;
  logic [1:0]                      next_cnt;
  logic                            next_data_ready_clock_true;
  logic                            load;
  logic                            rst_entry;
  logic                            next_rst_out;
  logic                            addr_take;
  logic                            ctrl_write;
  logic                            wr_pending_ctrl;
  logic [1:0]                      ctrl_view;
  logic [31:0]                     status_word;
  logic [31:0]                     read_word;
  logic [31:0]                     next_hrdata;
  logic [adcdm_pkg::SAMPLE_DEPTH-1:0][adcdm_pkg::SAMPLE_W-1:0] sample_taps;
  logic [adcdm_pkg::RST_DEPTH-1:0][0:0]                        rst_taps;

  // Mode decode from the static enable and select bits.
  assign mode = !ctrl[adcdm_pkg::CTRL_SPLIT_BIT] ? adcdm_pkg::ADCDM_FULL :
                ctrl[adcdm_pkg::CTRL_DIVSEL_BIT] ? adcdm_pkg::ADCDM_QUARTER :
                                                   adcdm_pkg::ADCDM_HALF;

  // Each leg of the reset pair passes two flops; the pair is active when true beats comp.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_pin_meta <= 2'h1;
      rst_pin_sync <= 2'h1;
    end else begin
      rst_pin_meta <= {sync_reset_in_true, sync_reset_in_comp};
      rst_pin_sync <= rst_pin_meta;
    end
  end

  assign reset_latched = rst_pin_sync[1] & ~rst_pin_sync[0];

  // Phase check and cycle swallowing.
  // Only the first latched cycle may swallow an edge, so the counter realigns once.
  assign rst_first    = reset_latched & ~aligned & ~swallow_seen;
  assign phase_match  = ((cnt ^ adcdm_pkg::RESET_PHASE) & phase_mask(mode)) == 2'h0;
  assign mismatch_now = rst_first & ~phase_match;
  assign next_cnt     = mismatch_now ? cnt : cnt + 2'h1;

  // The divided clock keeps running while the reset travels out.
  assign next_data_ready_clock_true = (mode == adcdm_pkg::ADCDM_HALF)    ? next_cnt[0] :
                       (mode == adcdm_pkg::ADCDM_QUARTER) ? next_cnt[1] :
                                                            ~data_ready_clock_true;
  assign load = (mode == adcdm_pkg::ADCDM_FULL) | (next_data_ready_clock_true & ~data_ready_clock_true);

  // A pulse that needed a dropped cycle never enters the reset pipeline.
  assign rst_entry    = reset_latched & ~swallow_seen & ~mismatch_now;
  assign next_rst_out = rst_taps[adcdm_pkg::RST_DEPTH-1][0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= adcdm_pkg::CNT_RESET;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aligned <= 1'b0;
    end else begin
      aligned <= reset_latched & (aligned | (rst_first & phase_match));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swallow_seen <= 1'b0;
    end else begin
      swallow_seen <= reset_latched & (swallow_seen | mismatch_now);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swallow_count <= 8'h00;
    end else if (mismatch_now) begin
      swallow_count <= swallow_count + 8'h01;
    end
  end

  // Sample and reset pipelines.
  adcdm_delay_line #(
    .WIDTH (adcdm_pkg::SAMPLE_W),
    .DEPTH (adcdm_pkg::SAMPLE_DEPTH)
  ) u_sample_line (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (sample_in),
    .taps  (sample_taps)
  );

  adcdm_delay_line #(
    .WIDTH (1),
    .DEPTH (adcdm_pkg::RST_DEPTH)
  ) u_reset_line (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (rst_entry),
    .taps  (rst_taps)
  );

  // Data-ready clock, both legs from their own flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_clock_true <= 1'b0;
    end else begin
      data_ready_clock_true <= next_data_ready_clock_true;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_clock_comp <= 1'b1;
    end else begin
      data_ready_clock_comp <= ~next_data_ready_clock_true;
    end
  end

  // Port loading: the older sample of each pair lands on the auxiliary port.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_data <= '0;
    end else if (load) begin
      primary_data <= sample_taps[adcdm_pkg::PRI_TAP];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_data <= '0;
    end else if (load && mode != adcdm_pkg::ADCDM_FULL) begin
      aux_data <= sample_taps[adcdm_pkg::AUX_TAP];
    end
  end

  // Aligned reset output, both legs from their own flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aligned_reset_out_true <= 1'b0;
    end else begin
      aligned_reset_out_true <= next_rst_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aligned_reset_out_comp <= 1'b1;
    end else begin
      aligned_reset_out_comp <= ~next_rst_out;
    end
  end

  // Bus slave: zero wait states, always OKAY.
  assign addr_take       = hsel & hready & (htrans == adcdm_pkg::HTRANS_NONSEQ) &
                           (hsize == adcdm_pkg::HSIZE_WORD);
  assign ctrl_write      = ap_valid & ap_write & ap_ctrl;
  assign wr_pending_ctrl = ctrl_write;
  assign ctrl_view       = wr_pending_ctrl ? hwdata[1:0] : ctrl;

  assign status_word = {16'h0000, swallow_count, 3'h0, aligned,
                        aligned_reset_out_true, reset_latched, cnt};

  assign read_word = addr_hit(haddr, adcdm_pkg::CTRL_OFFSET)   ? {30'h0, ctrl_view} :
                     addr_hit(haddr, adcdm_pkg::STATUS_OFFSET) ? status_word :
                                                                  32'h0000_0000;
  assign next_hrdata = (addr_take & ~hwrite) ? read_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_ctrl  <= 1'b0;
    end else begin
      ap_valid <= addr_take;
      ap_write <= hwrite;
      ap_ctrl  <= addr_hit(haddr, adcdm_pkg::CTRL_OFFSET);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= adcdm_pkg::CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= adcdm_pkg::HRESP_OKAY;
    end else begin
      hresp <= adcdm_pkg::HRESP_OKAY;
    end
  end

endmodule

`default_nettype wire

// ===== adcdm_pkg.sv
`default_nettype none

package adcdm_pkg;

  // Register map, byte addresses on the bus.
  localparam logic [31:0] CTRL_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0004;

  // Control register fields.
  localparam int unsigned CTRL_SPLIT_BIT  = 0;
  localparam int unsigned CTRL_DIVSEL_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // Status register fields.
  localparam int unsigned STAT_CNT_LSB     = 0;
  localparam int unsigned STAT_LATCHED_BIT = 2;
  localparam int unsigned STAT_ALIGNED_RESET_OUT_TRUE_BIT  = 3;
  localparam int unsigned STAT_ALIGNED_BIT = 4;
  localparam int unsigned STAT_SWALLOW_LSB = 8;

  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Latencies in half sample clock cycles, and the whole cycles they map to.
  localparam int unsigned LAT_PRI_HALF = 15;
  localparam int unsigned LAT_AUX_HALF = 17;
  localparam int unsigned LAT_RST_HALF = 13;
  localparam int unsigned LAT_PRI_CYC  = LAT_PRI_HALF / 2;
  localparam int unsigned LAT_AUX_CYC  = LAT_AUX_HALF / 2;
  localparam int unsigned LAT_RST_CYC  = LAT_RST_HALF / 2;

  // Pipeline taps: one edge enters the line, one edge loads the output flop.
  localparam int unsigned PRI_TAP      = LAT_PRI_CYC - 2;
  localparam int unsigned AUX_TAP      = LAT_AUX_CYC - 2;
  localparam int unsigned SAMPLE_DEPTH = AUX_TAP + 1;
  localparam int unsigned RST_DEPTH    = LAT_RST_CYC - 1;

  localparam int unsigned SAMPLE_W = 8;

  // Divide counter phases.
  localparam logic [1:0] CNT_RESET   = 2'h1;
  localparam logic [1:0] RESET_PHASE = 2'h0;

  typedef enum logic [1:0] {
    ADCDM_FULL    = 2'b00,
    ADCDM_HALF    = 2'b01,
    ADCDM_QUARTER = 2'b10
  } adcdm_mode_e;

endpackage

`default_nettype wire

// ===== adcdm_delay_line.sv
`timescale 1ns/1ps
`default_nettype none

module adcdm_delay_line #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [WIDTH-1:0]            din,
  output logic      [DEPTH-1:0][WIDTH-1:0] taps
);

  // Tap k holds the input delayed by k plus one edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taps[0] <= '0;
    end else begin
      taps[0] <= din;
    end
  end

  genvar k;
  generate
    for (k = 1; k < DEPTH; k++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          taps[k] <= '0;
        end else begin
          taps[k] <= taps[k-1];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== adcdm_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module adcdm_chk #(
  parameter int unsigned W = adcdm_pkg::SAMPLE_W
) (
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic [W-1:0] sample_in,
  input wire logic         sync_reset_in_true,
  input wire logic         sync_reset_in_comp,
  input wire logic [W-1:0] primary_data,
  input wire logic [W-1:0] aux_data,
  input wire logic         data_ready_clock_true,
  input wire logic         data_ready_clock_comp,
  input wire logic         aligned_reset_out_true,
  input wire logic         aligned_reset_out_comp
);
  logic [3:0] warm_cnt;
  logic       warm;
  logic       pin_on;

  assign warm   = &warm_cnt;
  assign pin_on = sync_reset_in_true & ~sync_reset_in_comp;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_cnt <= 4'h0;
    end else if (!warm) begin
      warm_cnt <= warm_cnt + 4'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence dr_rise_s;
    warm && $rose(data_ready_clock_true);
  endsequence

  sequence dr_fall_s;
    ##[1:4] $fell(data_ready_clock_true);
  endsequence

  dr_legs_a: assert property (data_ready_clock_comp == !data_ready_clock_true)
    else $error("data ready legs not complementary");
  rst_legs_a: assert property (aligned_reset_out_comp == !aligned_reset_out_true)
    else $error("reset output legs not complementary");
  pri_latency_a: assert property (dr_rise_s |-> primary_data == $past(sample_in, 7))
    else $error("primary port latency wrong");
  aux_older_a: assert property (
    warm && $changed(aux_data) |-> $rose(data_ready_clock_true) && aux_data == $past(sample_in, 8))
    else $error("auxiliary port update wrong");
  rst_rise_a: assert property (
    warm && $rose(aligned_reset_out_true) |-> $past(pin_on, 8) && !$past(pin_on, 9))
    else $error("reset output rise misplaced");
  rst_fall_a: assert property (
    warm && $fell(aligned_reset_out_true) |-> $past(pin_on, 9) && !$past(pin_on, 8))
    else $error("reset output fall misplaced");
  dr_high_a: assert property (dr_rise_s |-> dr_fall_s)
    else $error("data ready stuck high");
  dr_run_a: assert property (
    aligned_reset_out_true |-> ##[1:2] $changed(data_ready_clock_true))
    else $error("data ready stopped during reset output");
  rst_idle_a: assert property ((!pin_on) [*8] |=> !aligned_reset_out_true)
    else $error("reset output without reset input");
endmodule

bind adcdm_top adcdm_chk u_chk (
  .hclk,
  .hresetn,
  .sample_in,
  .sync_reset_in_true,
  .sync_reset_in_comp,
  .primary_data,
  .aux_data,
  .data_ready_clock_true,
  .data_ready_clock_comp,
  .aligned_reset_out_true,
  .aligned_reset_out_comp
);

`default_nettype wire

// ===== adcdm_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcdm_far_model #(
  parameter int unsigned W = adcdm_pkg::SAMPLE_W
) (
  input  wire logic         hclk,
  input  wire logic [W-1:0] pri,
  input  wire logic [W-1:0] aux,
  input  wire logic         dr_true,
  input  wire logic         rst_true,
  output logic      [W-1:0] cap_pri,
  output logic      [W-1:0] cap_aux
);
  logic dr_q;

  // Captures both ports on each data-ready rise; clears both while the reset output is high.
  always_ff @(posedge hclk) begin
    dr_q <= dr_true;
    if (rst_true) begin
      cap_pri <= '0;
      cap_aux <= '0;
    end else if (dr_true && !dr_q) begin
      cap_pri <= pri;
      cap_aux <= aux;
    end
  end
endmodule

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int          W    = adcdm_pkg::SAMPLE_W;
  localparam logic [31:0] CTRL = adcdm_pkg::CTRL_OFFSET;
  localparam logic [31:0] STAT = adcdm_pkg::STATUS_OFFSET;

  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic         rsp;
  logic [W-1:0] smp = '0;
  logic         rin_t = 1'b0;
  logic         rin_c = 1'b1;
  logic [W-1:0] pri, aux, cp, ca;
  logic         dr_t, dr_c, ro_t, ro_c, dr_q;
  logic [31:0]  q, s0;
  int           err_total = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  int           a, b, p, ph, ph0, m;

  adcdm_top DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .sample_in(smp),
    .sync_reset_in_true(rin_t), .sync_reset_in_comp(rin_c),
    .primary_data(pri), .aux_data(aux),
    .data_ready_clock_true(dr_t), .data_ready_clock_comp(dr_c),
    .aligned_reset_out_true(ro_t), .aligned_reset_out_comp(ro_c)
  );

  adcdm_far_model FAR (
    .hclk, .pri, .aux, .dr_true(dr_t), .rst_true(ro_t), .cap_pri(cp), .cap_aux(ca)
  );

  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    smp <= smp + 8'h01;
    cyc <= cyc + 1;
    dr_q <= dr_t;
  end

  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    hsize <= adcdm_pkg::HSIZE_WORD;
    htrans <= adcdm_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    rsp = hresp;
  endtask

  task automatic rd(input logic [31:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(q, e);
    chk(32'(rsp), 32'(adcdm_pkg::HRESP_OKAY));
  endtask

  task automatic next_rise(output int r);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      if (dr_t === 1'b1 && dr_q === 1'b0) break;
    end
    r = cyc;
  endtask

  task automatic rst_test(input int tgt, input logic t, input logic c, input int sw);
    logic o;
    o = 1'b0;
    next_rise(a);
    while (cyc < tgt) @(posedge hclk);
    rin_t <= t;
    rin_c <= c;
    p = cyc;
    repeat (2) @(posedge hclk);
    rin_t <= 1'b0;
    rin_c <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      o = o | (ro_t === 1'b1);
    end
    next_rise(b);
    ph = (b - p) % 2;
    if (sw >= 0) chk((b - a) % 2, sw);
    if (sw >= 0) chk(32'(o), 32'(t && !c && sw == 0));
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL, 32'h0);
    bus(1'b1, 32'h10, 32'hffff_ffff);
    rd(32'h10, 32'h0);
    for (m = 0; m < 4; m++) begin
      bus(1'b1, CTRL, m);
      rd(CTRL, m);
      repeat (12) @(posedge hclk);
      next_rise(a);
      next_rise(b);
      chk(b - a, (m == 3) ? 4 : 2);
      s0 = 32'(aux);
      repeat (8) @(posedge hclk);
      chk(32'(aux === s0[W-1:0]), 32'(!m[0]));
      if (m[0]) chk(32'(W'(cp - ca)), 32'h1);
    end
    bus(1'b1, CTRL, 32'h1);
    repeat (12) @(posedge hclk);
    rst_test(cyc + 4, 1'b1, 1'b0, -1);
    ph0 = ph;
    bus(1'b0, STAT, 32'h0);
    s0 = q;
    rst_test(p + 40, 1'b1, 1'b0, 0);
    chk(ph, ph0);
    bus(1'b0, STAT, 32'h0);
    chk(q[4:2], 3'h0);
    chk(q[15:8], s0[15:8]);
    rst_test(p + 41, 1'b1, 1'b0, 1);
    chk(ph, ph0);
    bus(1'b0, STAT, 32'h0);
    chk(q[15:8], s0[15:8] + 8'h01);
    rst_test(p + 41, 1'b1, 1'b1, 0);
    bus(1'b0, STAT, 32'h0);
    chk(q[15:8], s0[15:8] + 8'h01);
    close_out;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    err_total++;
    close_out;
  end
endmodule

`default_nettype wire
